/* rtl/usm_pkg.sv */
// Purpose: shared constants for the synchronous serial transceiver
// Assumes: APB slave with byte addresses on 32-bit aligned words
// Notes: bit positions follow the control register layouts
package usm_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_BAUD_CTL = 8'h00;
  localparam logic [7:0] OFF_RX_STAT = 8'h04;
  localparam logic [7:0] OFF_DIV_LO = 8'h08;
  localparam logic [7:0] OFF_DIV_HI = 8'h0c;
  localparam logic [7:0] OFF_TX_HOLD = 8'h10;
  localparam logic [7:0] OFF_TX_STAT = 8'h14;
  localparam logic [7:0] OFF_RX_DATA = 8'h18;
  localparam logic [7:0] OFF_IRQ_CTL = 8'h1c;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BC_POLARITY = 4;
  localparam int BC_WIDE_DIV = 3;
  localparam int RS_PORT_EN = 7;
  localparam int RS_RX_NINE = 6;
  localparam int RS_SINGLE = 5;
  localparam int RS_CONT = 4;
  localparam int RS_OVERRUN = 1;
  localparam int RS_RX_NINTH_BIT = 0;
  localparam int TS_MASTER = 7;
  localparam int TS_TX_NINE = 6;
  localparam int TS_TX_EN = 5;
  localparam int TS_SYNC = 4;
  localparam int TS_HIGH_SPD = 2;
  localparam int TS_SHIFT_IDLE = 1;
  localparam int TS_TX_NINTH_BIT = 0;
  localparam int IC_GLOBAL = 7;
  localparam int IC_PERIPH = 6;
  localparam int IC_RX_EN = 5;
  localparam int IC_TX_EN = 4;
  localparam int IC_RX_READY = 1;
  localparam int IC_TX_EMPTY = 0;
  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
endpackage

/* rtl/usm_sync_serial.sv */
// Purpose: synchronous half-duplex serial transceiver, master or slave
// Assumes: APB access; zero wait states; pins sampled on clk
// Notes: clearing port enable resets the shift logic, fifo and flags
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
module usm_sync_serial
  import usm_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // data line
  input wire logic data_line_i,
  output logic data_line_o,
  output logic data_line_oe,
  // clock line
  input wire logic clock_line_i,
  output logic clock_line_o,
  output logic clock_line_oe,
  // core wake and vector requests
  output logic wake_req,
  output logic vector_req
);
  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  logic polarity_r, wide_div_r;
  logic port_enable_r, rx_nine_bit_sel_r, single_receive_en_r, continuous_receive_en_r;
  logic clock_source_master_r, tx_nine_bit_sel_r, transmit_en_r, sync_mode_r;
  logic baud_high_speed_r, tx_ninth_bit_r;
  logic [7:0] div_lo_r, div_hi_r;
  logic global_irq_en_r, periph_irq_en_r, rx_irq_en_r, tx_irq_en_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  // ---------------------------------------------------------------
  // unit state
  // ---------------------------------------------------------------
  logic [8:0] hold_r, shift_tx_r, shift_rx_r;
  logic hold_full_r, tx_busy_r;
  logic [3:0] tcnt_r, rcnt_r;
  logic [8:0] fifo_r [0:1];
  logic head_r;
  logic [1:0] cnt_r;
  logic overrun_r, overrun_cont_r;
  logic act_r;
  logic [15:0] tmr_r;
  logic data_r, cont_prev_r;
  logic ck_s1_r, ck_s2_r, ck_s3_r, dt_s1_r, dt_s2_r;
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire [7:0] addr8 = paddr[7:0];
  wire hit_bc = addr8 == OFF_BAUD_CTL;
  wire hit_rs = addr8 == OFF_RX_STAT;
  wire hit_lo = addr8 == OFF_DIV_LO;
  wire hit_hi = addr8 == OFF_DIV_HI;
  wire hit_th = addr8 == OFF_TX_HOLD;
  wire hit_ts = addr8 == OFF_TX_STAT;
  wire hit_rd = addr8 == OFF_RX_DATA;
  wire hit_ic = addr8 == OFF_IRQ_CTL;
  wire mapped = hit_bc | hit_rs | hit_lo | hit_hi | hit_th | hit_ts | hit_rd | hit_ic;
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire wr = acc & pwrite & mapped;
  wire [7:0] wd = pwdata[7:0];
  wire pop = acc & ~pwrite & hit_rd & (cnt_r != 2'h0);
  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  wire u_rst = rst | ~port_enable_r;
  wire sync_on = port_enable_r & sync_mode_r;
  wire master = sync_on & clock_source_master_r;
  wire slave = sync_on & ~clock_source_master_r;
  wire rx_en = master ? (single_receive_en_r | continuous_receive_en_r)
                      : (slave & continuous_receive_en_r);
  wire tx_mode = sync_on & ~single_receive_en_r & ~continuous_receive_en_r
                 & transmit_en_r;
  wire [3:0] tbits = tx_nine_bit_sel_r ? BITS_NINE : BITS_EIGHT;
  wire [3:0] rbits = rx_nine_bit_sel_r ? BITS_NINE : BITS_EIGHT;
  wire [15:0] div = wide_div_r ? {div_hi_r, div_lo_r} : {8'h00, div_lo_r};
  // ---------------------------------------------------------------
  // shift clock events
  // ---------------------------------------------------------------
  wire master_run = master & ((tx_mode & tx_busy_r) | (rx_en & ~overrun_r));
  wire half = tmr_r == div;
  wire s_act = ck_s2_r ^ polarity_r;
  wire s_prev = ck_s3_r ^ polarity_r;
  wire lead_ev = master ? (master_run & half & ~act_r) : (slave & s_act & ~s_prev);
  wire trail_ev = master ? (master_run & half & act_r) : (slave & ~s_act & s_prev);
  wire cont_fall = cont_prev_r & ~continuous_receive_en_r;
  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  wire rx_step = trail_ev & rx_en & ~overrun_r;
  wire [8:0] rsr_nxt = {dt_s2_r, shift_rx_r[8:1]};
  wire [8:0] rx_char = rx_nine_bit_sel_r ? rsr_nxt : {1'b0, rsr_nxt[8:1]};
  wire rx_done = rx_step & (rcnt_r == rbits - 4'h1);
  wire fifo_full = (cnt_r == FIFO_DEPTH) & ~pop;
  wire push = rx_done & ~fifo_full;
  wire ovr_set = rx_done & fifo_full;
  // a push beside a pop on a full fifo takes the slot being freed
  wire tail = head_r ^ cnt_r[0];
  wire [8:0] head_char = fifo_r[head_r];
  wire rx_ready_flag = cnt_r != 2'h0;
  wire ovr_clr = (pop & ~overrun_cont_r) | (cont_fall & overrun_cont_r);
  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  wire load_tsr = tx_mode & hold_full_r & ~tx_busy_r;
  wire tx_last = trail_ev & tx_busy_r & (tcnt_r == tbits - 4'h1);
  wire tx_empty_flag = ~hold_full_r;
  wire hold_wr = wr & hit_th;
  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire [7:0] rd_bc = {3'h0, polarity_r, wide_div_r, 3'h0};
  wire [7:0] rd_rs = {port_enable_r, rx_nine_bit_sel_r, single_receive_en_r,
                      continuous_receive_en_r, 2'h0, overrun_r, head_char[8]};
  wire [7:0] rd_ts = {clock_source_master_r, tx_nine_bit_sel_r, transmit_en_r,
                      sync_mode_r, 1'b0, baud_high_speed_r, ~tx_busy_r, tx_ninth_bit_r};
  wire [7:0] rd_ic = {global_irq_en_r, periph_irq_en_r, rx_irq_en_r, tx_irq_en_r,
                      2'h0, rx_ready_flag, tx_empty_flag};
  wire [7:0] rd_byte = hit_bc ? rd_bc :
                       hit_rs ? rd_rs :
                       hit_lo ? div_lo_r :
                       hit_hi ? div_hi_r :
                       hit_ts ? rd_ts :
                       hit_rd ? head_char[7:0] :
                       hit_ic ? rd_ic : 8'h00;
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  wire irq_pend = periph_irq_en_r & ((tx_irq_en_r & tx_empty_flag & transmit_en_r)
                  | (rx_irq_en_r & rx_ready_flag));
  assign wake_req = irq_pend;
  assign vector_req = irq_pend & global_irq_en_r;
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = pslverr_r;
  assign data_line_o = data_r;
  assign data_line_oe = tx_mode;
  assign clock_line_o = act_r ^ polarity_r;
  assign clock_line_oe = master & (transmit_en_r | rx_en);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
      dt_s1_r <= 1'b0;
      dt_s2_r <= 1'b0;
    end
    else
    begin
      ck_s1_r <= clock_line_i;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
      dt_s1_r <= data_line_i;
      dt_s2_r <= dt_s1_r;
    end
  end
  // ---------------------------------------------------------------
  // apb response
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end
    else if (setup)
    begin
      prdata_r <= {24'h0, rd_byte};
      pslverr_r <= ~mapped;
    end
  end
  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {polarity_r, wide_div_r} <= 2'h0;
      {port_enable_r, rx_nine_bit_sel_r, continuous_receive_en_r} <= 3'h0;
      {clock_source_master_r, tx_nine_bit_sel_r, transmit_en_r, sync_mode_r} <= 4'h0;
      {baud_high_speed_r, tx_ninth_bit_r} <= 2'h0;
      div_lo_r <= RST_BYTE;
      div_hi_r <= RST_BYTE;
      {global_irq_en_r, periph_irq_en_r, rx_irq_en_r, tx_irq_en_r} <= 4'h0;
    end
    else if (wr)
    begin
      if (hit_bc)
      begin
        polarity_r <= wd[BC_POLARITY];
        wide_div_r <= wd[BC_WIDE_DIV];
      end
      if (hit_rs)
      begin
        port_enable_r <= wd[RS_PORT_EN];
        rx_nine_bit_sel_r <= wd[RS_RX_NINE];
        continuous_receive_en_r <= wd[RS_CONT];
      end
      if (hit_lo)
        div_lo_r <= wd;
      if (hit_hi)
        div_hi_r <= wd;
      if (hit_ts)
      begin
        clock_source_master_r <= wd[TS_MASTER];
        tx_nine_bit_sel_r <= wd[TS_TX_NINE];
        transmit_en_r <= wd[TS_TX_EN];
        sync_mode_r <= wd[TS_SYNC];
        baud_high_speed_r <= wd[TS_HIGH_SPD];
        tx_ninth_bit_r <= wd[TS_TX_NINTH_BIT];
      end
      if (hit_ic)
      begin
        global_irq_en_r <= wd[IC_GLOBAL];
        periph_irq_en_r <= wd[IC_PERIPH];
        rx_irq_en_r <= wd[IC_RX_EN];
        tx_irq_en_r <= wd[IC_TX_EN];
      end
    end
  end
  // single receive clears itself after one master character
  always_ff @(posedge clk)
  begin
    if (rst)
      single_receive_en_r <= 1'b0;
    else if (wr & hit_rs)
      single_receive_en_r <= wd[RS_SINGLE];
    else if (rx_done & master)
      single_receive_en_r <= 1'b0;
  end
  // ---------------------------------------------------------------
  // master shift clock generator
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (u_rst | ~master_run)
    begin
      act_r <= 1'b0;
      tmr_r <= 16'h0;
    end
    else if (half)
    begin
      act_r <= ~act_r;
      tmr_r <= 16'h0;
    end
    else
      tmr_r <= tmr_r + 16'h1;
  end
  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (u_rst)
    begin
      hold_r <= 9'h0;
      hold_full_r <= 1'b0;
    end
    else if (hold_wr)
    begin
      hold_r <= {tx_ninth_bit_r, wd};
      hold_full_r <= 1'b1;
    end
    else if (load_tsr)
      hold_full_r <= 1'b0;
  end
  always_ff @(posedge clk)
  begin
    if (u_rst | ~tx_mode)
    begin
      tx_busy_r <= 1'b0;
      tcnt_r <= 4'h0;
      shift_tx_r <= 9'h0;
    end
    else if (load_tsr)
    begin
      tx_busy_r <= 1'b1;
      tcnt_r <= 4'h0;
      shift_tx_r <= hold_r;
    end
    else if (tx_last)
      tx_busy_r <= 1'b0;
    else if (trail_ev & tx_busy_r)
      tcnt_r <= tcnt_r + 4'h1;
  end
  // data changes on the leading edge, holds to the next one
  always_ff @(posedge clk)
  begin
    if (u_rst)
      data_r <= 1'b0;
    else if (lead_ev & tx_busy_r)
      data_r <= shift_tx_r[tcnt_r];
  end
  // ---------------------------------------------------------------
  // receiver shifter
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (u_rst)
      cont_prev_r <= 1'b0;
    else
      cont_prev_r <= continuous_receive_en_r;
  end
  always_ff @(posedge clk)
  begin
    if (u_rst | ~rx_en | cont_fall | rx_done)
      rcnt_r <= 4'h0;
    else if (rx_step)
      rcnt_r <= rcnt_r + 4'h1;
  end
  always_ff @(posedge clk)
  begin
    if (u_rst)
      shift_rx_r <= 9'h0;
    else if (rx_step)
      shift_rx_r <= rsr_nxt;
  end
  // ---------------------------------------------------------------
  // receive fifo and overrun
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (u_rst)
    begin
      fifo_r[0] <= 9'h0;
      fifo_r[1] <= 9'h0;
    end
    else if (push)
      fifo_r[tail] <= rx_char;
  end
  always_ff @(posedge clk)
  begin
    if (u_rst)
    begin
      head_r <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (pop)
        head_r <= ~head_r;
      if (push & ~pop)
        cnt_r <= cnt_r + 2'h1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 2'h1;
    end
  end
  always_ff @(posedge clk)
  begin
    if (u_rst)
    begin
      overrun_r <= 1'b0;
      overrun_cont_r <= 1'b0;
    end
    else if (ovr_set & ~overrun_r)
    begin
      overrun_r <= 1'b1;
      overrun_cont_r <= continuous_receive_en_r;
    end
    else if (ovr_clr)
      overrun_r <= 1'b0;
  end
endmodule

/* test/usm_peer_model.sv */
// Purpose: far end of the serial link, clock source or clock follower
// Assumes: clock polarity 0, leading edge rising
// Notes: a data line released by both ends reads high by pull-up
`timescale 1ns/1ps
module usm_peer_model (
  // lines from the block
  input wire logic m_clk,
  input wire logic m_clk_oe,
  input wire logic d_o,
  input wire logic d_oe,
  // peer controls
  input wire logic drv_en,
  input wire logic [8:0] pat,
  input wire logic [3:0] nb,
  // lines into the block
  output logic ck_in,
  output logic dt_in,
  // captured traffic
  output logic [17:0] cap,
  output int cnt
);
  logic s_clk = 1'b0;
  logic bit_q = 1'b1;
  int k = 0;
  // link clock stands low outside frames
  assign ck_in = m_clk_oe ? m_clk : s_clk;
  assign dt_in = d_oe ? d_o : (drv_en ? bit_q : 1'b1);
  always @(posedge ck_in)
    bit_q = pat[k % nb];
  always @(negedge ck_in)
  begin
    cap = {dt_in, cap[17:1]};
    cnt++;
    k++;
  end
  task automatic frame(input int n);
    repeat (n)
    begin
      #24 s_clk = 1'b1;
      #24 s_clk = 1'b0;
    end
  endtask
  task automatic clear();
    k = 0;
    cnt = 0;
    cap = 18'h00000;
  endtask
endmodule

/* test/usm_sync_serial_chk.sv */
// Purpose: port checks on the synchronous serial transceiver
// Assumes: clock polarity 0 and a small divisor
// Notes: control bytes are shadowed from apb writes
`timescale 1ns/1ps
module usm_sync_serial_chk
  import usm_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock, reset and apb
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // lines and requests
  input wire logic data_line_i,
  input wire logic data_line_o,
  input wire logic data_line_oe,
  input wire logic clock_line_i,
  input wire logic clock_line_o,
  input wire logic clock_line_oe,
  input wire logic wake_req,
  input wire logic vector_req
);
  logic [7:0] rx_sh, tx_sh, ic_sh;
  logic [15:0] lead_cnt;
  logic ck_q;
  wire wr = psel && penable && pwrite && pready;
  wire wr_rx = wr && paddr[7:0] == OFF_RX_STAT;
  wire wr_hold = wr && paddr[7:0] == OFF_TX_HOLD;
  wire master = rx_sh[RS_PORT_EN] && tx_sh[TS_MASTER] && tx_sh[TS_SYNC];
  wire rx_on = rx_sh[RS_SINGLE] || rx_sh[RS_CONT];
  wire lead = clock_line_oe && clock_line_o && !ck_q;
  // ---------------------------------------------------------------
  // control shadows and leading-edge count
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    ck_q <= clock_line_o;
    if (rst)
    begin
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      ic_sh <= 8'h00;
    end
    else if (wr)
    begin
      if (paddr[7:0] == OFF_RX_STAT)
        rx_sh <= pwdata[7:0];
      if (paddr[7:0] == OFF_TX_STAT)
        tx_sh <= pwdata[7:0];
      if (paddr[7:0] == OFF_IRQ_CTL)
        ic_sh <= pwdata[7:0];
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst || wr_rx)
      lead_cnt <= 16'h0000;
    else if (lead)
      lead_cnt <= lead_cnt + 16'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_unmapped_err: assert property (psel && penable && paddr[7:0] > OFF_IRQ_CTL |-> pslverr)
    else $error("unmapped access without error");
  a_tx_starts: assert property (
    wr_hold && master && tx_sh[TS_TX_EN] && !rx_on |-> ##[1:300] $changed(clock_line_o))
    else $error("holding write started no clock");
  a_cont_clocks: assert property (
    wr_rx && pwdata[RS_CONT] && pwdata[RS_PORT_EN] && tx_sh[TS_MASTER] && tx_sh[TS_SYNC]
    |-> ##[2:40] $changed(clock_line_o))
    else $error("continuous receive gave no clock");
  a_single_count: assert property (
    rx_sh[RS_SINGLE] && !rx_sh[RS_CONT] |-> lead_cnt <= (rx_sh[RS_RX_NINE] ? 16'h0009 : 16'h0008))
    else $error("single receive clocked too many bits");
  a_stop_clock: assert property (
    wr_rx && !pwdata[RS_CONT] && !pwdata[RS_SINGLE] |-> ##2 !clock_line_o [*4])
    else $error("shift clock kept running");
  a_no_tx_in_rx: assert property (rx_sh[RS_CONT] |-> !data_line_oe)
    else $error("data driven while receiving");
  a_clk_drive: assert property (
    master && (tx_sh[TS_TX_EN] || rx_sh[RS_CONT]) |-> clock_line_oe)
    else $error("master clock line not driven");
  a_slave_noclk: assert property (!tx_sh[TS_MASTER] |-> !clock_line_oe)
    else $error("slave drives clock line");
  a_data_hold: assert property (
    clock_line_oe && data_line_oe && $past(data_line_oe) && $changed(data_line_o)
    |-> $rose(clock_line_o))
    else $error("data changed away from leading edge");
  a_vector_wake: assert property (
    vector_req |-> wake_req && ic_sh[IC_GLOBAL] && ic_sh[IC_PERIPH])
    else $error("vector without wake and enables");
endmodule

/* test/usm_sync_serial_tb_top.sv */
// Purpose: self-checking bench for the synchronous serial transceiver
// Assumes: zero-wait apb, clock polarity 0, divisor 3
// Notes: the peer model stands on the far side of both lines
`timescale 1ns/1ps
module usm_sync_serial_tb_top;
  import usm_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic dt_o, dt_oe, ck_o, ck_oe, ck_in, dt_in, wake_req, vector_req, drv_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [8:0] pat;
  logic [3:0] nb;
  logic [17:0] cap;
  int cnt, num_errors, total_checks;
  logic [7:0] offs [5] = '{OFF_BAUD_CTL, OFF_RX_STAT, OFF_DIV_LO, OFF_DIV_HI, OFF_RX_DATA};
  usm_sync_serial #(.ADDR_W(8)) dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_line_i(dt_in), .data_line_o(dt_o), .data_line_oe(dt_oe),
    .clock_line_i(ck_in), .clock_line_o(ck_o), .clock_line_oe(ck_oe),
    .wake_req(wake_req), .vector_req(vector_req));
  usm_peer_model peer_u (.m_clk(ck_o), .m_clk_oe(ck_oe), .d_o(dt_o), .d_oe(dt_oe),
    .drv_en(drv_en), .pat(pat), .nb(nb), .ck_in(ck_in), .dt_in(dt_in), .cap(cap), .cnt(cnt));
  always #2.5 clk = ~clk;
  // ---------------------------------------------------------------
  // reporting and bus tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tmo(input string w);
    num_errors++;
    $display("MISMATCH %s expected done seen hang", w);
    summarize();
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd,
    output logic [31:0] rd, output logic er);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50)
      tmo("apb ready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, a, v, d, e);
  endtask
  task automatic chkr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 8'h00, d, e);
    chk($sformatf("reg %h", a), x, d & m);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int i;
    i = 0;
    do
    begin
      apb(1'b0, a, 8'h00, d, e);
      i++;
    end while (d[b] !== v && i < 400);
    if (i >= 400)
      tmo("register flag");
  endtask
  task automatic wait_cnt(input int n);
    int i;
    i = 0;
    while (cnt < n && i < 5000)
    begin
      @(posedge clk);
      i++;
    end
    if (i >= 5000)
      tmo("peer bit count");
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    drv_en = 1'b0;
    pat = 9'h000;
    nb = 4'h8;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (offs[i]) chkr(offs[i], 32'hffffffff, 32'h00000000);
    apb(1'b0, 8'h20, 8'h00, d, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, d);
    wr(OFF_BAUD_CTL, 8'h18);
    chkr(OFF_BAUD_CTL, 32'hff, 32'h18);
    chk("idle polarity", 32'h1, {31'h0, ck_o});
    wr(OFF_BAUD_CTL, 8'h00);
    $display("test registers done");
    wr(OFF_DIV_LO, 8'h03);
    chkr(OFF_DIV_LO, 32'hff, 32'h03);
    wr(OFF_RX_STAT, 8'h80);
    wr(OFF_TX_STAT, 8'hf1);
    peer_u.clear();
    wr(OFF_TX_HOLD, 8'h3c);
    wait_cnt(9);
    chk("tx nine", 32'h13c, {23'h0, cap[17:9]});
    poll(OFF_TX_STAT, TS_SHIFT_IDLE, 1'b1);
    wr(OFF_TX_STAT, 8'hb0);
    peer_u.clear();
    wr(OFF_TX_HOLD, 8'ha5);
    wr(OFF_TX_HOLD, 8'h5a);
    wait_cnt(16);
    chk("tx pair", 32'h5aa5, {16'h0, cap[17:2]});
    poll(OFF_TX_STAT, TS_SHIFT_IDLE, 1'b1);
    $display("test master transmit done");
    wr(OFF_TX_STAT, 8'h90);
    pat <= 9'h05a;
    drv_en <= 1'b1;
    peer_u.clear();
    wr(OFF_RX_STAT, 8'ha0);
    poll(OFF_IRQ_CTL, IC_RX_READY, 1'b1);
    chkr(OFF_RX_STAT, 32'hff, 32'h80);
    chkr(OFF_RX_DATA, 32'hff, 32'h5a);
    chkr(OFF_IRQ_CTL, 32'h02, 32'h00);
    nb <= 4'h9;
    pat <= 9'h1c3;
    peer_u.clear();
    wr(OFF_RX_STAT, 8'he0);
    poll(OFF_IRQ_CTL, IC_RX_READY, 1'b1);
    pat <= 9'h03c;
    peer_u.clear();
    wr(OFF_RX_STAT, 8'he0);
    poll(OFF_RX_STAT, RS_SINGLE, 1'b0);
    wr(OFF_RX_STAT, 8'he0);
    poll(OFF_RX_STAT, RS_OVERRUN, 1'b1);
    chkr(OFF_RX_STAT, 32'h01, 32'h01);
    chkr(OFF_RX_DATA, 32'hff, 32'hc3);
    chkr(OFF_RX_STAT, 32'h03, 32'h00);
    chkr(OFF_RX_DATA, 32'hff, 32'h3c);
    chkr(OFF_IRQ_CTL, 32'h02, 32'h00);
    $display("test master single receive done");
    nb <= 4'h8;
    pat <= 9'h096;
    peer_u.clear();
    wr(OFF_RX_STAT, 8'hb0);
    wait_cnt(16);
    pat <= 9'h069;
    wait_cnt(24);
    poll(OFF_RX_STAT, RS_OVERRUN, 1'b1);
    chkr(OFF_RX_STAT, 32'hff, 32'h92);
    wr(OFF_RX_STAT, 8'h80);
    chkr(OFF_RX_STAT, 32'hff, 32'h80);
    chkr(OFF_RX_DATA, 32'hff, 32'h96);
    chkr(OFF_RX_DATA, 32'hff, 32'h96);
    pat <= 9'h096;
    peer_u.clear();
    wr(OFF_RX_STAT, 8'h90);
    wait_cnt(4);
    wr(OFF_RX_STAT, 8'h80);
    chkr(OFF_IRQ_CTL, 32'h02, 32'h00);
    $display("test continuous receive done");
    wr(OFF_TX_STAT, 8'h10);
    wr(OFF_RX_STAT, 8'h90);
    pat <= 9'h0a7;
    peer_u.clear();
    peer_u.frame(8);
    poll(OFF_IRQ_CTL, IC_RX_READY, 1'b1);
    chkr(OFF_RX_DATA, 32'hff, 32'ha7);
    wr(OFF_RX_STAT, 8'h80);
    drv_en <= 1'b0;
    wr(OFF_IRQ_CTL, 8'h50);
    wr(OFF_TX_STAT, 8'h30);
    peer_u.clear();
    wr(OFF_TX_HOLD, 8'h11);
    wr(OFF_TX_HOLD, 8'h22);
    chkr(OFF_IRQ_CTL, 32'h01, 32'h00);
    chk("wake idle", 32'h0, {31'h0, wake_req});
    peer_u.frame(8);
    poll(OFF_IRQ_CTL, IC_TX_EMPTY, 1'b1);
    chk("wake", 32'h1, {31'h0, wake_req});
    chk("slave first", 32'h11, {24'h0, cap[17:10]});
    peer_u.clear();
    peer_u.frame(8);
    wait_cnt(8);
    chk("slave second", 32'h22, {24'h0, cap[17:10]});
    wr(OFF_IRQ_CTL, 8'hd0);
    @(posedge clk);
    chk("vector", 32'h1, {31'h0, vector_req});
    $display("test slave mode done");
    summarize();
  end
endmodule
bind usm_sync_serial usm_sync_serial_chk #(.ADDR_W(ADDR_W)) chk_u (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_line_i(data_line_i),
  .data_line_o(data_line_o), .data_line_oe(data_line_oe), .clock_line_i(clock_line_i),
  .clock_line_o(clock_line_o), .clock_line_oe(clock_line_oe), .wake_req(wake_req),
  .vector_req(vector_req));
